// File: sec_map.vh
// Constants of the serial EEPROM core: instruction codes, status layout, timing
`ifndef SEC_MAP_VH
`define SEC_MAP_VH
`define SEC_OP_LATCH_SET   8'h06
`define SEC_OP_LATCH_CLEAR 8'h04
`define SEC_OP_STAT_READ   8'h05
`define SEC_OP_STAT_WRITE  8'h01
`define SEC_OP_MEM_READ    8'h03
`define SEC_OP_MEM_WRITE   8'h02
`define SEC_STAT_ONES      4'hf
`define SEC_BIT_LAST       3'h7
`define SEC_BIT_FIRST      3'h0
`define SEC_PAGE_LAST      4'hf
`define SEC_ADDR_C0        8'hc0
`define SEC_ADDR_80        8'h80
`define SEC_PROG_NS        5000000
`define SEC_CLK_NS         8
`define SEC_ERASED         8'hff
`endif

// File: sec_fifo.v
// Parameterised FIFO that holds page write data between serial link and array
`timescale 1ns/100ps
`default_nettype none
module sec_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wp_r;
  reg [AW:0]      rp_r;
  wire            full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire            empty = (wp_r == rp_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  // Storage write and combinational head
  always @(posedge sys_clk)
  begin
    if (in_valid && !full)
      mem_r[wp_r[AW-1:0]] <= in_data;
  end
  always @*
  begin
    out_data = mem_r[rp_r[AW-1:0]];
  end
  // Pointers
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wp_r <= wp_r + 1'b1;
      if (out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sec_mem.v
// Byte array of the EEPROM with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "sec_map.vh"
module sec_mem #(
  parameter AW = 8
) (
  input  wire          sys_clk,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data
);
  reg [7:0] mem_r [0:(1<<AW)-1];
  integer   i;
  // Array starts fully erased
  initial
  begin
    for (i = 0; i < (1<<AW); i = i + 1)
      mem_r[i] = `SEC_ERASED;
  end
  // Write port and registered read port
  always @(posedge sys_clk)
  begin
    if (wr_en)
      mem_r[wr_addr] <= wr_data;
    rd_data <= mem_r[rd_addr];
  end
endmodule
`default_nettype wire

// File: sec_core.v
// Serial EEPROM core: link decode, write latch, status, hold, protect, programming
`timescale 1ns/100ps
`default_nettype none
`include "sec_map.vh"
module sec_core #(
  parameter PROG_CYCLES = (`SEC_PROG_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS,
  parameter DEPTH       = 8
) (
  input  wire sys_clk,
  input  wire reset_n,
  input  wire link_clk,
  input  wire sel_n,
  input  wire din,
  input  wire hold_n,
  input  wire wprot_n,
  output reg  dout,
  output reg  dout_oe,
  output reg  busy_out
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01, S_OP = 7'h02, S_ADDR = 7'h04, S_RDAT = 7'h08,
                   S_WDAT = 7'h10, S_STAT = 7'h20, S_WAIT = 7'h40;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [4:0] s1_r;
  reg [4:0] s2_r;
  reg       clk_d_r;
  reg       hold_d_r;
  reg       sel_d_r;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Idle pin levels, so that no false clock edge follows reset
      s1_r     <= 5'h1c;
      s2_r     <= 5'h1c;
      clk_d_r  <= 1'b0;
      hold_d_r <= 1'b1;
      sel_d_r  <= 1'b1;
    end
    else
    begin
      s1_r     <= {sel_n, hold_n, wprot_n, link_clk, din};
      s2_r     <= s1_r;
      clk_d_r  <= s2_r[1];
      hold_d_r <= s2_r[3];
      sel_d_r  <= s2_r[4];
    end
  end
  wire sel    = !s2_r[4];
  wire wp_ok  = s2_r[2];
  wire c_lvl  = s2_r[1];
  wire d_lvl  = s2_r[0];
  wire c_rise = c_lvl && !clk_d_r;
  wire c_fall = !c_lvl && clk_d_r;
  wire s_fall = sel && sel_d_r;
  wire s_rise = !sel && !sel_d_r;
  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  reg [6:0] st_r;
  reg       armed_r;
  reg       hold_r;
  reg       resume_oe_r;
  reg       latch_r;
  reg [1:0] prot_r;
  reg [1:0] prot_new_r;
  reg [7:0] sh_r;
  reg [2:0] bit_r;
  reg [7:0] op_r;
  reg [7:0] addr_r;
  reg [7:0] tx_r;
  reg       bytes_ok_r;
  reg       wp_fell_r;
  reg       prog_r;
  reg       stat_prog_r;
  reg [31:0] cnt_r;
  reg [7:0] base_r;
  wire [7:0] rd_data;
  wire [7:0] stat_byte = {`SEC_STAT_ONES, prot_r, latch_r, prog_r};
  wire [7:0] sh_nxt    = {sh_r[6:0], d_lvl};
  // Protected range check for one address
  function prot_hit;
    input [1:0] lvl;
    input [7:0] a;
    begin
      case (lvl)
        2'h0:    prot_hit = 1'b0;
        2'h1:    prot_hit = (a >= `SEC_ADDR_C0);
        2'h2:    prot_hit = (a >= `SEC_ADDR_80);
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction
  // ----------------------------------------------------------------
  // Write data buffer and array
  // ----------------------------------------------------------------
  wire [11:0] f_out;
  wire        f_valid;
  wire        f_ready;
  wire        f_push = (st_r == S_WDAT) && c_rise && !hold_r && (bit_r == `SEC_BIT_LAST)
                       && f_ready;
  wire        f_pop  = prog_r && !stat_prog_r && f_valid;
  wire [7:0]  w_addr = {base_r[7:4], f_out[11:8]};
  wire        w_en   = f_pop && !prot_hit(prot_r, w_addr);
  sec_fifo #(.WIDTH(12), .DEPTH(DEPTH), .AW(3)) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .flush     ((st_r == S_IDLE) && !prog_r),
    .in_data   ({addr_r[3:0], sh_nxt}),
    .in_valid  (f_push),
    .in_ready  (f_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );
  sec_mem #(.AW(8)) u_mem (
    .sys_clk (sys_clk),
    .rd_addr (addr_r),
    .rd_data (rd_data),
    .wr_en   (w_en),
    .wr_addr (w_addr),
    .wr_data (f_out[7:0])
  );
  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r        <= S_IDLE;
      armed_r     <= 1'b0;
      hold_r      <= 1'b0;
      latch_r     <= 1'b0;
      prot_r      <= 2'h0;
      prot_new_r  <= 2'h0;
      sh_r        <= 8'h00;
      bit_r       <= `SEC_BIT_FIRST;
      op_r        <= 8'h00;
      addr_r      <= 8'h00;
      tx_r        <= 8'h00;
      bytes_ok_r  <= 1'b0;
      wp_fell_r   <= 1'b0;
      prog_r      <= 1'b0;
      stat_prog_r <= 1'b0;
      cnt_r       <= 32'h0;
      base_r      <= 8'h00;
      dout        <= 1'b0;
      dout_oe     <= 1'b0;
      busy_out    <= 1'b0;
      resume_oe_r <= 1'b0;
    end
    else
    begin
      busy_out <= prog_r;
      // Self-timed cycle; nothing but the counter ends it
      if (prog_r)
      begin
        if (cnt_r == PROG_CYCLES - 1)
        begin
          prog_r <= 1'b0;
          latch_r <= 1'b0;
          if (stat_prog_r)
            prot_r <= prot_new_r;
          stat_prog_r <= 1'b0;
        end
        cnt_r <= cnt_r + 32'h1;
      end
      // Hold edges only while selected and clock low
      if (sel && !c_lvl && hold_d_r && !s2_r[3])
      begin
        hold_r      <= 1'b1;
        resume_oe_r <= dout_oe;
      end
      else if (sel && !c_lvl && !hold_d_r && s2_r[3])
        hold_r <= 1'b0;
      if (!wp_ok)
      begin
        latch_r   <= 1'b0;
        wp_fell_r <= 1'b1;
      end
      if (s_fall)
      begin
        armed_r   <= 1'b1;
        st_r      <= S_OP;
        bit_r     <= `SEC_BIT_FIRST;
        wp_fell_r <= !wp_ok;
        bytes_ok_r <= 1'b0;
      end
      else if (!sel)
      begin
        dout_oe <= 1'b0;
        resume_oe_r <= 1'b0;
        if (!hold_r && s_rise && bytes_ok_r && !wp_fell_r && wp_ok && !prog_r)
        begin
          if (op_r == `SEC_OP_STAT_WRITE && st_r == S_WAIT)
          begin
            prog_r <= 1'b1;
            stat_prog_r <= 1'b1;
            cnt_r <= 32'h0;
            latch_r <= 1'b0;
          end
          else if (op_r == `SEC_OP_MEM_WRITE && st_r == S_WDAT)
          begin
            prog_r <= 1'b1;
            cnt_r <= 32'h0;
            base_r <= addr_r;
          end
        end
        st_r <= S_IDLE;
        bytes_ok_r <= 1'b0;
      end
      else if (hold_r)
        dout_oe <= 1'b0;
      else if (armed_r)
      begin
        // First bit of each read byte comes straight from the array port
        if (c_fall && st_r == S_RDAT && bit_r == `SEC_BIT_FIRST)
        begin
          dout    <= rd_data[7];
          dout_oe <= 1'b1;
          tx_r    <= {rd_data[6:0], 1'b0};
        end
        else if (c_fall && (st_r == S_RDAT || st_r == S_STAT))
        begin
          dout    <= tx_r[7];
          dout_oe <= 1'b1;
          tx_r    <= {tx_r[6:0], 1'b0};
        end
        if (c_rise)
        begin
          sh_r  <= sh_nxt;
          bit_r <= bit_r + 3'h1;
          bytes_ok_r <= 1'b0;
          case (st_r)
            S_OP:
              if (bit_r == `SEC_BIT_LAST)
              begin
                op_r <= sh_nxt;
                if (sh_nxt == `SEC_OP_LATCH_SET)
                begin
                  latch_r <= wp_ok;
                  st_r <= S_WAIT;
                end
                else if (sh_nxt == `SEC_OP_LATCH_CLEAR)
                begin
                  latch_r <= 1'b0;
                  st_r <= S_WAIT;
                end
                else if (sh_nxt == `SEC_OP_STAT_READ)
                begin
                  tx_r <= stat_byte;
                  st_r <= S_STAT;
                end
                else if (sh_nxt == `SEC_OP_STAT_WRITE)
                  st_r <= (latch_r && !prog_r) ? S_ADDR : S_WAIT;
                else if (sh_nxt == `SEC_OP_MEM_READ)
                  st_r <= prog_r ? S_WAIT : S_ADDR;
                else if (sh_nxt == `SEC_OP_MEM_WRITE)
                  st_r <= (latch_r && wp_ok && !prog_r) ? S_ADDR : S_WAIT;
                else
                  st_r <= S_WAIT;
              end
            S_ADDR:
              if (bit_r == `SEC_BIT_LAST)
              begin
                if (op_r == `SEC_OP_STAT_WRITE)
                begin
                  prot_new_r <= sh_nxt[3:2];
                  bytes_ok_r <= 1'b1;
                  st_r <= S_WAIT;
                end
                else
                begin
                  addr_r <= sh_nxt;
                  st_r <= (op_r == `SEC_OP_MEM_READ) ? S_RDAT : S_WDAT;
                end
              end
            S_RDAT:
              if (bit_r == `SEC_BIT_LAST)
                addr_r <= addr_r + 8'h01;
            S_WDAT:
              if (bit_r == `SEC_BIT_LAST)
              begin
                addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
                bytes_ok_r <= 1'b1;
              end
            S_STAT:
              if (bit_r == `SEC_BIT_LAST)
                st_r <= S_WAIT;
            default:
              begin
                bytes_ok_r <= 1'b0;
                st_r <= S_WAIT;
              end
          endcase
        end
        if (st_r == S_WAIT && op_r != `SEC_OP_STAT_WRITE)
          dout_oe <= 1'b0;
      end
      // Leaving hold drives the output again if hold had floated it
      if (hold_r && sel && !c_lvl && !hold_d_r && s2_r[3])
        dout_oe <= resume_oe_r;
    end
  end
endmodule
`default_nettype wire

// File: sec_core_properties.sv
// Port checker of the serial EEPROM core
`timescale 1ns/100ps
`default_nettype none
module sec_core_properties #(
  parameter PROG_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic din,
  input wire logic hold_n,
  input wire logic wprot_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic busy_out
);
  // Length of the current busy stretch
  logic [31:0] bcnt_r;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      bcnt_r <= 32'h0;
    else if (busy_out)
      bcnt_r <= bcnt_r + 32'h1;
    else
      bcnt_r <= 32'h0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  desel_float_a: assert property (
    sel_n [*4] |-> !dout_oe) else $error("output driven while deselected");
  hold_float_a: assert property (
    !hold_n [*5] |-> !dout_oe) else $error("output driven during hold");
  reset_quiet_a: assert property (
    $rose(reset_n) |-> !busy_out && !dout_oe) else $error("outputs active after reset");
  busy_len_a: assert property (
    $fell(busy_out) |-> bcnt_r == PROG_CYCLES) else $error("busy length wrong");
  busy_max_a: assert property (
    busy_out |-> bcnt_r < PROG_CYCLES) else $error("busy too long");
  start_desel_a: assert property (
    $rose(busy_out) |-> sel_n && $past(sel_n)) else $error("write began while selected");
  protect_block_a: assert property (
    !wprot_n [*8] |-> !$rose(busy_out)) else $error("write began under protect");
  oe_selected_a: assert property (
    $rose(dout_oe) |-> !sel_n && hold_n) else $error("output enabled while idle");
  // Main scenarios seen
  cover property ($rose(busy_out));
  cover property ($rose(dout_oe));
  cover property (!sel_n && !hold_n);
endmodule
bind sec_core sec_core_properties #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk), .sel_n(sel_n),
  .din(din), .hold_n(hold_n), .wprot_n(wprot_n), .dout(dout),
  .dout_oe(dout_oe), .busy_out(busy_out));
`default_nettype wire

// File: sec_spi_master.sv
// Behavioural serial master for either clock idle level, facing the EEPROM core
`timescale 1ns/100ps
`default_nettype none
module sec_spi_master (
  input  wire logic sys_clk,
  input  wire logic dout,
  input  wire logic dout_oe,
  output var logic  link_clk,
  output var logic  sel_n,
  output var logic  din,
  output var logic  hold_n
);
  logic clk_idle_r;
  // Idle link: clock low, deselected, not held
  initial
  begin
    link_clk = 1'b0;
    sel_n = 1'b1;
    din = 1'b0;
    hold_n = 1'b1;
    clk_idle_r = 1'b0;
  end
  // Pick the idle level of the link clock; call only while deselected
  task automatic mode(input logic p);
    clk_idle_r = p;
    link_clk <= p;
    tick(4);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Shift n bits MSB first; a floating output reads as z
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'hzz;
    for (int i = 7; i > 7 - n; i--)
    begin
      if (clk_idle_r)
        link_clk <= 1'b0;
      din <= tx[i];
      tick(4);
      link_clk <= 1'b1;
      rx[i] = dout_oe ? dout : 1'bz;
      tick(4);
      if (!clk_idle_r)
        link_clk <= 1'b0;
    end
  endtask
  task automatic sel();
    sel_n <= 1'b0;
    tick(4);
  endtask
  // Deselect four cycles after the transfer ends, which is its last clock edge while the clock idles low
  task automatic desel();
    tick(4);
    sel_n <= 1'b1;
    tick(8);
  endtask
  // Hold moves only well after the clock has settled low
  task automatic pause(input logic v);
    tick(4);
    hold_n <= v;
    tick(6);
  endtask
endmodule
`default_nettype wire

// File: spi_eeprom_serial_core_bench.sv
// Self-checking bench of the serial EEPROM core
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_serial_core_bench;
  logic       sys_clk;
  logic       reset_n;
  logic       wprot_n;
  wire        link_clk, sel_n, din, hold_n, dout, dout_oe, busy_out;
  int         fails;
  int         comparisons;
  logic [7:0] s;
  logic [7:0] r0;
  logic [7:0] r1;
  sec_core #(.PROG_CYCLES(400)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk), .sel_n(sel_n),
    .din(din), .hold_n(hold_n), .wprot_n(wprot_n), .dout(dout),
    .dout_oe(dout_oe), .busy_out(busy_out));
  sec_spi_master m_u (
    .sys_clk(sys_clk), .dout(dout), .dout_oe(dout_oe), .link_clk(link_clk),
    .sel_n(sel_n), .din(din), .hold_n(hold_n));
  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic op(input logic [7:0] c);
    m_u.sel();
    m_u.xfer(c, 8, r1);
    m_u.desel();
  endtask
  task automatic stat(output logic [7:0] v);
    m_u.sel();
    m_u.xfer(8'h05, 8, v);
    m_u.xfer(8'h00, 8, v);
    m_u.desel();
  endtask
  // Latch set, then write d0, and d1 too when n > 1, from address a
  task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
    op(8'h06);
    m_u.sel();
    m_u.xfer(8'h02, 8, r1);
    m_u.xfer(a, 8, r1);
    m_u.xfer(d0, 8, r1);
    if (n > 1)
      m_u.xfer(d1, 8, r1);
    m_u.desel();
  endtask
  // Stream two bytes from address a
  task automatic rd(input logic [7:0] a);
    m_u.sel();
    m_u.xfer(8'h03, 8, r1);
    m_u.xfer(a, 8, r1);
    m_u.xfer(8'h00, 8, r0);
    m_u.xfer(8'h00, 8, r1);
    m_u.desel();
  endtask
  task automatic idle();
    for (int i = 0; i < 1000 && busy_out !== 1'b0; i++)
      m_u.tick(1);
    if (busy_out !== 1'b0)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latch();
    stat(s);
    check(s, 8'hf0);
    m_u.sel();
    m_u.xfer(8'h06, 8, r1);
    m_u.xfer(8'h05, 8, r1);
    m_u.xfer(8'h00, 8, r0);
    m_u.desel();
    check(r0, 8'hzz);
    stat(s);
    check(s, 8'hf2);
    op(8'h04);
    stat(s);
    check(s, 8'hf0);
    m_u.sel();
    m_u.xfer(8'hff, 8, r1);
    m_u.xfer(8'h05, 8, r1);
    m_u.xfer(8'h00, 8, r0);
    m_u.desel();
    check(r0, 8'hzz);
    $display("test latch done");
  endtask
  task automatic t_write();
    wr(8'hcf, 8'ha5, 8'h5a, 2);
    check({7'h0, busy_out}, 8'h01);
    stat(s);
    check(s & 8'hf1, 8'hf1);
    rd(8'hcf);
    check(r0, 8'hzz);
    idle();
    stat(s);
    check(s, 8'hf0);
    rd(8'hcf);
    check(r0, 8'ha5);
    check(r1, 8'hff);
    rd(8'hc0);
    check(r0, 8'h5a);
    $display("test write done");
  endtask
  task automatic t_swr();
    op(8'h06);
    m_u.sel();
    m_u.xfer(8'h01, 8, r1);
    m_u.xfer(8'h04, 8, r1);
    m_u.desel();
    check({7'h0, busy_out}, 8'h01);
    stat(s);
    check(s & 8'hfd, 8'hf1);
    idle();
    stat(s);
    check(s, 8'hf4);
    op(8'h06);
    m_u.sel();
    m_u.xfer(8'h01, 8, r1);
    m_u.xfer(8'h08, 8, r1);
    m_u.xfer(8'h00, 1, r1);
    m_u.desel();
    check({7'h0, busy_out}, 8'h00);
    stat(s);
    check(s & 8'hfd, 8'hf4);
    wr(8'hc0, 8'h00, 8'h00, 1);
    check({7'h0, busy_out}, 8'h01);
    idle();
    rd(8'hc0);
    check(r0, 8'h5a);
    $display("test status write done");
  endtask
  task automatic t_wprot();
    wprot_n <= 1'b0;
    op(8'h06);
    stat(s);
    check(s, 8'hf4);
    wr(8'h10, 8'h66, 8'h00, 1);
    check({7'h0, busy_out}, 8'h00);
    wprot_n <= 1'b1;
    wr(8'h10, 8'h66, 8'h00, 1);
    check({7'h0, busy_out}, 8'h01);
    idle();
    op(8'h06);
    m_u.sel();
    m_u.xfer(8'h02, 8, r1);
    m_u.xfer(8'h10, 8, r1);
    m_u.xfer(8'h55, 4, r1);
    wprot_n <= 1'b0;
    m_u.xfer(8'h50, 4, r1);
    m_u.desel();
    check({7'h0, busy_out}, 8'h00);
    wprot_n <= 1'b1;
    rd(8'h10);
    check(r0, 8'h66);
    $display("test protect pin done");
  endtask
  task automatic t_hold();
    m_u.sel();
    m_u.xfer(8'h05, 8, r1);
    m_u.pause(1'b0);
    check({7'h0, dout_oe}, 8'h00);
    m_u.pause(1'b1);
    m_u.xfer(8'h00, 8, s);
    m_u.desel();
    check(s, 8'hf4);
    // Deselect while held: the machine restarts, the pause persists
    m_u.sel();
    m_u.xfer(8'h05, 8, r1);
    m_u.pause(1'b0);
    m_u.desel();
    m_u.sel();
    m_u.xfer(8'h05, 8, r1);
    m_u.xfer(8'h00, 8, r0);
    check(r0, 8'hzz);
    m_u.pause(1'b1);
    m_u.xfer(8'h05, 8, r1);
    m_u.xfer(8'h00, 8, s);
    m_u.desel();
    check(s, 8'hf4);
    $display("test hold done");
  endtask
  // Latch, status and read traffic with the link clock idling high
  task automatic t_mode11();
    m_u.mode(1'b1);
    op(8'h06);
    stat(s);
    check(s, 8'hf6);
    op(8'h04);
    rd(8'hcf);
    check(r0, 8'ha5);
    check(r1, 8'hff);
    m_u.mode(1'b0);
    $display("test clock mode done");
  endtask
  // Reset, scenarios, verdict
  initial
  begin
    fails = 0;
    comparisons = 0;
    reset_n = 1'b0;
    wprot_n = 1'b1;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    m_u.tick(4);
    t_latch();
    t_write();
    t_swr();
    t_wprot();
    t_hold();
    t_mode11();
    tally_and_finish();
  end
endmodule
`default_nettype wire
